//--- rtl/bsms_boot_select.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Boot strap bit 0 picks internal ROM when 1, external flash when 0.
// - Internal boot takes its option from the three-bit option strap field.
// - Base ROM: 0 NOR, 1 reserved, 2 SPI slave, 3/4 NAND, 5/6 UART, 7 diag.
// - Extended ROM: 0/1 NOR A/B, 2 slave, 3 NAND, 4 IDE, 5 dev, 6 UART, 7 diag.
// - Extended differs for codes 1, 4 and 5, giving NOR B, IDE and dev; NAND stays on code 3.
// - Key scan drives the key pin low then high and samples the sense pin.
// - USB update starts only on extended ROM with USB present and key pressed or no boot dev.
// - Crystal straps decode to 24, 20, 13, 12, 10 MHz, others give 24 MHz.
// - Crystal straps are read first, before any boot device is tried.
// - Sampling hardware is the same for both ROM versions.

module bsms_boot_select
   import bsms_pkg::*;
(
   // Clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     rst_n,
   // Strap pins
   input  wire logic [bsms_pkg::STRAP_W-1:0] strapPins,
   input  wire logic [bsms_pkg::XTAL_W-1:0]  xtalPins,
   // ROM version select, 1 for extended
   input  wire logic                     extendedRomVersion,
   // Update key pins
   input  wire logic                     keySense,
   output logic                          keyDrive,
   output logic                          keyDriveOe,
   // System status
   input  wire logic                     usbPresent,
   input  wire logic                     noBootDevice,
   // Decoded results
   output logic                          stapsValid,
   output logic                          internalBoot,
   output logic [bsms_pkg::OPT_W-1:0]    bootOption,
   output bsms_pkg::bsms_dev_e           bootDevice,
   output logic                          smallBigBlock,
   output logic [4:0]                    xtalMhz,
   output logic                          keyPressed,
   output logic                          usbUpdate
);
   import bsms_pkg::*;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [STRAP_W-1:0] strapSync;
   logic [XTAL_W-1:0]  xtalSync;
   logic               keySync;

   bsms_sync3 #(.W(STRAP_W + XTAL_W + 1)) u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pinIn   ({keySense, xtalPins, strapPins}),
      .pinOut  ({keySync, xtalSync, strapSync})
   );

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_SETTLE, ST_XTAL, ST_STRAP, ST_KEY_LO, ST_KEY_HI, ST_DONE
   } bsms_state_e;

   bsms_state_e        state;
   logic [KEY_CNT_W-1:0] cnt;
   logic [2:0]         settle;
   logic               senseLo;
   logic [OPT_W-1:0]   opt;

   localparam logic [KEY_CNT_W-1:0] KEY_LAST =
      KEY_CNT_W'(KEY_DRIVE_CYC - 1);

   assign opt = strapSync[OPT_LSB +: OPT_W];

   // Settle counter lets the synchroniser fill after reset
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         settle <= 3'h0;
      end else if (state == ST_SETTLE) begin
         settle <= settle + 3'h1;
      end
   end

   // Step through crystal, straps, then the key scan
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state <= ST_SETTLE;
         cnt   <= '0;
      end else begin
         unique case (state)
            ST_SETTLE: begin
               if (settle == 3'h7) begin
                  state <= ST_XTAL;
               end
            end
            ST_XTAL:   state <= ST_STRAP;
            ST_STRAP:  state <= ST_KEY_LO;
            ST_KEY_LO: begin
               if (cnt == KEY_LAST) begin
                  cnt   <= '0;
                  state <= ST_KEY_HI;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            ST_KEY_HI: begin
               if (cnt == KEY_LAST) begin
                  cnt   <= '0;
                  state <= ST_DONE;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            ST_DONE:   state <= ST_DONE;
         endcase
      end
   end

   // ----------------------------------------
   // Crystal frequency decode
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         xtalMhz <= XTAL_MHZ_24;
      end else if (state == ST_XTAL) begin
         case (xtalSync)
            XTAL_CODE_24: xtalMhz <= XTAL_MHZ_24;
            XTAL_CODE_20: xtalMhz <= XTAL_MHZ_20;
            XTAL_CODE_13: xtalMhz <= XTAL_MHZ_13;
            XTAL_CODE_12: xtalMhz <= XTAL_MHZ_12;
            XTAL_CODE_10: xtalMhz <= XTAL_MHZ_10;
            default:      xtalMhz <= XTAL_MHZ_24;
         endcase
      end
   end

   // ----------------------------------------
   // Boot strap capture and decode
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         internalBoot  <= 1'b0;
         bootOption    <= '0;
         bootDevice    <= BSMS_EXT_FLASH;
         smallBigBlock <= 1'b0;
      end else if (state == ST_STRAP) begin
         internalBoot  <= (strapSync[BOOT_SRC_POS] == BOOT_INTERNAL);
         bootOption    <= opt;
         smallBigBlock <= 1'b0;
         if (strapSync[BOOT_SRC_POS] != BOOT_INTERNAL) begin
            bootDevice <= BSMS_EXT_FLASH;
         end else if (!extendedRomVersion) begin
            unique case (opt)
               OPT_NOR_A:     bootDevice <= BSMS_NOR_A;
               OPT_NOR_B:     bootDevice <= BSMS_RESERVED;
               OPT_SPI_SLAVE: bootDevice <= BSMS_SPI_SLAVE;
               OPT_NAND, OPT_NAND_IDE: begin
                  bootDevice    <= BSMS_NAND;
                  smallBigBlock <= 1'b1;
               end
               OPT_UART_A, OPT_UART_B: bootDevice <= BSMS_UART;
               OPT_UART_DIAG: bootDevice <= BSMS_UART_DIAG;
            endcase
         end else begin
            unique case (opt)
               OPT_NOR_A:     bootDevice <= BSMS_NOR_A;
               OPT_NOR_B:     bootDevice <= BSMS_NOR_B;
               OPT_SPI_SLAVE: bootDevice <= BSMS_SPI_SLAVE;
               OPT_NAND:      bootDevice <= BSMS_NAND;
               OPT_NAND_IDE:  bootDevice <= BSMS_IDE;
               OPT_UART_A:    bootDevice <= BSMS_DEV_MODE;
               OPT_UART_B:    bootDevice <= BSMS_UART;
               OPT_UART_DIAG: bootDevice <= BSMS_UART_DIAG;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Update key scan
   // ----------------------------------------
   // Drive low, then high; key closed means sense follows drive
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         keyDrive   <= 1'b0;
         keyDriveOe <= 1'b0;
      end else begin
         keyDrive   <= (state == ST_KEY_HI) &&
                       !(cnt == KEY_LAST);
         keyDriveOe <= ((state == ST_KEY_LO) || (state == ST_KEY_HI)) &&
                       !((state == ST_KEY_HI) && (cnt == KEY_LAST));
      end
   end

   // Sample sense at end of each drive level
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         senseLo    <= 1'b1;
         keyPressed <= 1'b0;
      end else begin
         if (state == ST_KEY_LO && cnt == KEY_LAST) begin
            senseLo <= keySync;
         end
         if (state == ST_KEY_HI && cnt == KEY_LAST) begin
            keyPressed <= !senseLo && keySync;
         end
      end
   end

   // ----------------------------------------
   // USB update decision and valid flag
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         usbUpdate  <= 1'b0;
         stapsValid <= 1'b0;
      end else begin
         stapsValid <= (state == ST_DONE);
         usbUpdate  <= (state == ST_DONE) && extendedRomVersion &&
                       usbPresent && (keyPressed || noBootDevice);
      end
   end

endmodule // bsms_boot_select

`default_nettype wire

//--- rtl/bsms_pkg.sv
package bsms_pkg;

   // ----------------------------------------
   // Strap field widths and positions
   // ----------------------------------------
   localparam int unsigned OPT_W        = 3;
   localparam int unsigned XTAL_W       = 3;
   localparam int unsigned BOOT_SRC_POS = 0;   // Bit 0 of the strap port
   localparam int unsigned OPT_LSB      = 1;   // Bits 3:1 of the strap port
   localparam int unsigned STRAP_W      = 4;

   // ----------------------------------------
   // Boot source and option codes
   // ----------------------------------------
   localparam logic          BOOT_INTERNAL  = 1'h1;
   localparam logic [2:0]    OPT_NOR_A      = 3'h0;
   localparam logic [2:0]    OPT_NOR_B      = 3'h1;
   localparam logic [2:0]    OPT_SPI_SLAVE  = 3'h2;
   localparam logic [2:0]    OPT_NAND       = 3'h3;
   localparam logic [2:0]    OPT_NAND_IDE   = 3'h4;
   localparam logic [2:0]    OPT_UART_A     = 3'h5;
   localparam logic [2:0]    OPT_UART_B     = 3'h6;
   localparam logic [2:0]    OPT_UART_DIAG  = 3'h7;

   // ----------------------------------------
   // Crystal strap codes and frequencies (MHz)
   // ----------------------------------------
   localparam logic [2:0]    XTAL_CODE_24   = 3'h0;
   localparam logic [2:0]    XTAL_CODE_20   = 3'h1;
   localparam logic [2:0]    XTAL_CODE_13   = 3'h2;
   localparam logic [2:0]    XTAL_CODE_12   = 3'h3;
   localparam logic [2:0]    XTAL_CODE_10   = 3'h4;
   localparam logic [4:0]    XTAL_MHZ_24    = 5'h18;
   localparam logic [4:0]    XTAL_MHZ_20    = 5'h14;
   localparam logic [4:0]    XTAL_MHZ_13    = 5'h0d;
   localparam logic [4:0]    XTAL_MHZ_12    = 5'h0c;
   localparam logic [4:0]    XTAL_MHZ_10    = 5'h0a;

   // ----------------------------------------
   // Key scan timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned KEY_DRIVE_NS   = 1000;  // Drive time per level
   localparam int unsigned KEY_DRIVE_CYC  =
      (KEY_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned KEY_CNT_W      = 8;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [3:0] {
      BSMS_EXT_FLASH,
      BSMS_NOR_A,
      BSMS_NOR_B,
      BSMS_SPI_SLAVE,
      BSMS_NAND,
      BSMS_IDE,
      BSMS_DEV_MODE,
      BSMS_UART,
      BSMS_UART_DIAG,
      BSMS_RESERVED
   } bsms_dev_e;

endpackage

//--- rtl/bsms_sync3.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser; output moves when stages two and three agree
module bsms_sync3 #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   // Pin side
   input  wire logic [W-1:0] pinIn,
   // Clean side
   output logic      [W-1:0] pinOut
);

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // Shift chain and agreement filter, one per bit
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               s1[i]     <= 1'b0;
               s2[i]     <= 1'b0;
               s3[i]     <= 1'b0;
               pinOut[i] <= 1'b0;
            end else begin
               s1[i] <= pinIn[i];
               s2[i] <= s1[i];
               s3[i] <= s2[i];
               if (s2[i] == s3[i]) begin
                  pinOut[i] <= s3[i];
               end
            end
         end
      end
   endgenerate

endmodule // bsms_sync3

`default_nettype wire

//--- tb/bsms_key_model.sv
`timescale 1ns/1ps
`default_nettype none

// Update key between drive and sense pins, sense pulled up
module bsms_key_model (
   // Key state from the bench
   input  wire logic keyDown,
   // Pins at the select block
   input  wire logic keyDrive,
   input  wire logic keyDriveOe,
   output logic      keySense
);
   // Pressed key shorts sense to the driven level
   assign keySense = (keyDown && keyDriveOe) ? keyDrive : 1'b1;
endmodule // bsms_key_model

`default_nettype wire

//--- tb/bsms_boot_select_chk.sv
`timescale 1ns/1ps
`default_nettype none

// Port checks on strap decode, key scan and update start
module bsms_boot_select_chk
   import bsms_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // Pins and status
   input  wire logic [3:0] strapPins,
   input  wire logic [2:0] xtalPins,
   input  wire logic       extendedRomVersion,
   input  wire logic       keySense,
   input  wire logic       keyDrive,
   input  wire logic       keyDriveOe,
   input  wire logic       usbPresent,
   input  wire logic       noBootDevice,
   // Results
   input  wire logic       stapsValid,
   input  wire logic       internalBoot,
   input  wire logic [2:0] bootOption,
   input  wire bsms_dev_e  bootDevice,
   input  wire logic       smallBigBlock,
   input  wire logic [4:0] xtalMhz,
   input  wire logic       keyPressed,
   input  wire logic       usbUpdate
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // Steps of the update decision and the key scan
   sequence usbAsk_s;
      stapsValid && extendedRomVersion && usbPresent && noBootDevice;
   endsequence
   sequence usbOff_s;
      stapsValid && (!usbPresent || !extendedRomVersion);
   endsequence
   sequence keyLow_s;
      keyDriveOe && !keyDrive;
   endsequence

   ext_flash_a: assert property (stapsValid && !internalBoot |->
      bootDevice == BSMS_EXT_FLASH) else $error("external boot wrong");
   ide_code_a: assert property (stapsValid && bootDevice == BSMS_IDE |->
      extendedRomVersion && bootOption == 3'h4) else $error("ide wrong");
   nand_block_a: assert property (stapsValid && internalBoot |->
      smallBigBlock == (!extendedRomVersion && bootOption inside {3'h3, 3'h4}))
      else $error("autodetect flag wrong");
   xtal_code_a: assert property (stapsValid |->
      xtalMhz inside {5'h18, 5'h14, 5'h0d, 5'h0c, 5'h0a})
      else $error("crystal value wrong");
   held_values_a: assert property (stapsValid |=> stapsValid &&
      $stable(bootDevice) && $stable(xtalMhz) && $stable(keyPressed))
      else $error("captured value moved");
   key_start_a: assert property ($rose(keyDriveOe) |-> keyLow_s [*8])
      else $error("key scan not low first");
   key_order_a: assert property (keyDriveOe && keyDrive |=> !keyLow_s)
      else $error("key low after high");
   scan_first_a: assert property (keyDriveOe |->
      !stapsValid && $stable(xtalMhz)) else $error("scan order wrong");
   usb_start_a: assert property (usbAsk_s [*3] |-> usbUpdate)
      else $error("update not started");
   usb_quiet_a: assert property (usbOff_s [*3] |-> !usbUpdate)
      else $error("update started wrongly");

   // Sense seen low while the key pin was driven low
   logic lowSeen;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         lowSeen <= 1'b0;
      end else if (keyDriveOe && !keyDrive && !keySense) begin
         lowSeen <= 1'b1;
      end
   end

   key_sense_a: assert property ($fell(keyDriveOe) |->
      keyPressed == (lowSeen && $past(keySense)))
      else $error("key sense wrong");
   strap_capture_a: assert property ($rose(stapsValid) |->
      internalBoot == $past(strapPins[0]) &&
      bootOption == $past(strapPins[3:1]))
      else $error("strap capture wrong");
   xtal_capture_a: assert property ($rose(stapsValid) |->
      xtalMhz == (($past(xtalPins) == 3'h1) ? XTAL_MHZ_20 :
                  ($past(xtalPins) == 3'h2) ? XTAL_MHZ_13 :
                  ($past(xtalPins) == 3'h3) ? XTAL_MHZ_12 :
                  ($past(xtalPins) == 3'h4) ? XTAL_MHZ_10 : XTAL_MHZ_24))
      else $error("crystal capture wrong");
endmodule // bsms_boot_select_chk

bind bsms_boot_select bsms_boot_select_chk u_chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .strapPins(strapPins),
   .xtalPins(xtalPins), .extendedRomVersion(extendedRomVersion),
   .keySense(keySense), .keyDrive(keyDrive), .keyDriveOe(keyDriveOe),
   .usbPresent(usbPresent), .noBootDevice(noBootDevice),
   .stapsValid(stapsValid), .internalBoot(internalBoot),
   .bootOption(bootOption), .bootDevice(bootDevice),
   .smallBigBlock(smallBigBlock), .xtalMhz(xtalMhz),
   .keyPressed(keyPressed), .usbUpdate(usbUpdate)
);

`default_nettype wire

//--- tb/tb_boot_strap_mode_select.sv
`timescale 1ns/1ps
`default_nettype none

module tb_boot_strap_mode_select;
   import bsms_pkg::*;
   logic       ref_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [3:0] strapPins = 4'h0;
   logic [2:0] xtalPins = 3'h0;
   logic       extendedRomVersion = 1'b0;
   logic       usbPresent = 1'b0;
   logic       noBootDevice = 1'b0;
   logic       keyDown = 1'b0;
   logic       keySense, keyDrive, keyDriveOe, stapsValid, internalBoot;
   logic       smallBigBlock, keyPressed, usbUpdate;
   logic [2:0] bootOption;
   logic [4:0] xtalMhz, scanXtal;
   bsms_dev_e  bootDevice;
   int         bad_count = 0;
   int         samples_checked = 0;
   int         lowCyc, highCyc;

   always #5 ref_clk = ~ref_clk;

   bsms_boot_select DUT (.ref_clk(ref_clk), .rst_n(rst_n),
      .strapPins(strapPins), .xtalPins(xtalPins),
      .extendedRomVersion(extendedRomVersion), .keySense(keySense),
      .keyDrive(keyDrive), .keyDriveOe(keyDriveOe),
      .usbPresent(usbPresent), .noBootDevice(noBootDevice),
      .stapsValid(stapsValid), .internalBoot(internalBoot),
      .bootOption(bootOption), .bootDevice(bootDevice),
      .smallBigBlock(smallBigBlock), .xtalMhz(xtalMhz),
      .keyPressed(keyPressed), .usbUpdate(usbUpdate));
   bsms_key_model u_key (.keyDown(keyDown), .keyDrive(keyDrive),
      .keyDriveOe(keyDriveOe), .keySense(keySense));

   // ------
   // Helpers
   // ------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic bsms_dev_e expDev(input logic [3:0] s, input logic e);
      if (!s[0]) return BSMS_EXT_FLASH;
      case (s[3:1])
         3'h0: return BSMS_NOR_A;
         3'h1: return e ? BSMS_NOR_B : BSMS_RESERVED;
         3'h2: return BSMS_SPI_SLAVE;
         3'h3: return BSMS_NAND;
         3'h4: return e ? BSMS_IDE : BSMS_NAND;
         3'h5: return e ? BSMS_DEV_MODE : BSMS_UART;
         3'h6: return BSMS_UART;
         default: return BSMS_UART_DIAG;
      endcase
   endfunction

   function automatic logic [4:0] expMhz(input logic [2:0] x);
      case (x)
         3'h1: return XTAL_MHZ_20;
         3'h2: return XTAL_MHZ_13;
         3'h3: return XTAL_MHZ_12;
         3'h4: return XTAL_MHZ_10;
         default: return XTAL_MHZ_24;
      endcase
   endfunction

   // Reset with given straps, then wait for the decode to finish
   task automatic boot(input logic [3:0] s, input logic [2:0] x,
                       input logic e, input logic k);
      int n;
      rst_n = 1'b0;
      strapPins = s;
      xtalPins = x;
      extendedRomVersion = e;
      keyDown = k;
      repeat (10) @(negedge ref_clk);
      rst_n = 1'b1;
      n = 0;
      lowCyc = 0;
      highCyc = 0;
      while (stapsValid !== 1'b1 && n < 1000) begin
         @(negedge ref_clk);
         n++;
         if (keyDriveOe === 1'b1 && lowCyc == 0) scanXtal = xtalMhz;
         if (keyDriveOe === 1'b1 && keyDrive === 1'b0) lowCyc++;
         if (keyDriveOe === 1'b1 && keyDrive === 1'b1) highCyc++;
      end
      check(stapsValid, 1'b1);
   endtask

   // ------
   // Scenarios
   // ------
   task automatic decodeSweep;
      logic [4:0] i;
      logic       expBlock;
      for (int j = 0; j < 32; j++) begin
         i = 5'(j);
         boot(i[3:0], i[2:0], i[4], i[1]);
         check(internalBoot, i[0]);
         if (i[0]) check(bootOption, i[3:1]);
         check(bootDevice, expDev(i[3:0], i[4]));
         expBlock = !i[4] && i[0] && (i[3:1] inside {3'h3, 3'h4});
         check(smallBigBlock, expBlock);
         check(xtalMhz, expMhz(i[2:0]));
         check(keyPressed, i[1]);
      end
      $display("decode sweep done");
   endtask

   task automatic keyTiming;
      boot(4'h1, 3'h2, 1'b1, 1'b1);
      check(8'(lowCyc), 8'(KEY_DRIVE_CYC));
      check(8'(highCyc), 8'(KEY_DRIVE_CYC - 1));
      check(scanXtal, XTAL_MHZ_13);
      $display("key timing done");
   endtask

   task automatic holdCheck;
      boot(4'h9, 3'h4, 1'b1, 1'b0);
      strapPins = 4'h6;
      xtalPins = 3'h1;
      keyDown = 1'b1;
      repeat (300) @(negedge ref_clk);
      check(internalBoot, 1'b1);
      check(bootDevice, BSMS_IDE);
      check(xtalMhz, XTAL_MHZ_10);
      check(keyPressed, 1'b0);
      $display("hold check done");
   endtask

   task automatic usbCheck;
      logic [3:0] i;
      for (int j = 0; j < 16; j++) begin
         i = 4'(j);
         boot(4'h1, 3'h0, i[3], i[2]);
         usbPresent = i[0];
         noBootDevice = i[1];
         repeat (3) @(negedge ref_clk);
         check(usbUpdate, i[3] && i[0] && (i[2] || i[1]));
         usbPresent = 1'b0;
         noBootDevice = 1'b0;
      end
      $display("usb check done");
   endtask

   task automatic summarize;
      $display("checked %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      @(negedge ref_clk);
      decodeSweep();
      keyTiming();
      holdCheck();
      usbCheck();
      summarize();
   end

   // Watchdog
   initial begin
      repeat (30000) @(posedge ref_clk);
      bad_count++;
      summarize();
   end
endmodule // tb_boot_strap_mode_select

`default_nettype wire
